// File: common/acc_pkg.sv
// constants and types for the converter control block
package acc_pkg;
  localparam int RES_W       = 12;   // result bits
  localparam int WORD_W      = 32;   // result register width
  localparam int RES_LSB     = 16;   // result field position
  localparam int FIFO_W      = 32;
  localparam int FIFO_D      = 16;
  localparam logic [2:0] DIV_RST  = 3'h1;  // divide by 2
  localparam logic [1:0] ACQ_RST  = 2'h2;  // eight clocks
  localparam logic [2:0] DIV_TEMP = 3'h5;  // divide by 32
  localparam logic [1:0] ACQ_TEMP = 2'h3;  // sixteen clocks
  localparam logic [2:0] DIV_MAX  = 3'h5;
  localparam logic [4:0] ACQ_BASE = 5'h02; // two clocks for code 00
  localparam logic [3:0] TEMP_CH  = 4'hf;  // temperature sensor channel
  localparam logic [3:0] BIT_TOP  = 4'hb;  // first bit trial index
  localparam logic [5:0] DIV_ONE  = 6'h01;
  // input configuration
  typedef enum logic [1:0] {
    ACC_MODE_DIFF   = 2'h0,
    ACC_MODE_SINGLE = 2'h1,
    ACC_MODE_PSEUDO = 2'h2
  } acc_mode_t;
  // trigger source
  typedef enum logic [2:0] {
    ACC_TRG_EXTPIN = 3'h0,
    ACC_TRG_TMR0   = 3'h1,
    ACC_TRG_TMR1   = 3'h2,
    ACC_TRG_SWSING = 3'h3,
    ACC_TRG_SWCONT = 3'h4,
    ACC_TRG_PLA    = 3'h5
  } acc_trig_t;
  // sequencer states, one hot
  typedef enum logic [3:0] {
    ACC_ST_IDLE  = 4'h1,
    ACC_ST_ACQ   = 4'h2,
    ACC_ST_TRIAL = 4'h4,
    ACC_ST_WRITE = 4'h8
  } acc_state_t;
endpackage : acc_pkg

// File: core/acc_ctrl.sv
// converter control: triggers, sequencing, result coding, result queue
// Contract
// - resolve each sample to 12 bits by successive approximation, one result each.
// - support fully differential, single-ended and pseudo differential input configurations.
// - software starts one conversion or continuous conversions, chosen by configuration.
// - accept triggers from external start pin, logic array output, timer overflows.
// - temperature sensor is one extra selectable channel through same path.
// - single-ended and pseudo differential results are straight binary, 4096 steps.
// - fully differential results are twos complement, step two reference over 4096.
// - differential result is eleven bits plus sign, shifted right by one.
// - sequencing sustains one million samples per second at fastest settings.
// - result sits in bits 16 to 27, upper four bits filled with sign.
// - enable bit gates new starts; clearing does not stop continuous conversion.
// - temperature channel forces 16 acquisition clocks, divide 32, then restores.
// - acquisition field codes 00..11 give 2, 4, 8, 16 clocks; default 10.
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        convEnable,
  input  wire logic [1:0]  inputMode,
  input  wire logic [2:0]  trigSource,
  input  wire logic [2:0]  clkDivSel,
  input  wire logic [1:0]  acqTimeSel,
  input  wire logic [3:0]  channelSel,
  input  wire logic        swStart,
  input  wire logic        ext_start_pin_n,
  input  wire logic        programmable_logic_array_output,
  input  wire logic        timer0Overflow,
  input  wire logic        timer1Overflow,
  input  wire logic        cmpAbove,
  input  wire logic        resultRead,
  output logic             sampleHold_q,
  output logic             muxTemp_q,
  output logic [3:0]       muxChannel_q,
  output logic [1:0]       muxMode_q,
  output logic [11:0]      dacTrial_q,
  output logic             resultValid_q,
  output logic [31:0]      conversion_result_register,
  output logic             convComplete_q,
  output logic             busy_q,
  output logic             overrun_q
);
  acc_pkg::acc_state_t state_q;
  logic [11:0] sar_q;
  logic [3:0]  bitIdx_q;
  logic [5:0]  divCnt_q;
  logic [4:0]  acqCnt_q;
  logic [2:0]  divUse_q;
  logic [1:0]  acqUse_q;
  logic        contRun_q;
  logic        extPrev_q;
  logic        plaPrev_q;
  logic        trigHit;
  logic        startReq;
  logic        tick;
  logic [5:0]  divLoad;
  logic [4:0]  acqLoad;
  logic [11:0] trialNext;
  logic [31:0] resultWord;
  logic        fifoInReady;
  logic        fifoOutValid;
  logic [31:0] fifoOutData;
  logic        pushResult;
  logic        popResult;

  // pin and logic array trigger on edges, timer overflows on level; pin is active low so a falling edge starts
  always_comb begin
    case (acc_pkg::acc_trig_t'(trigSource))
      acc_pkg::ACC_TRG_EXTPIN: trigHit = extPrev_q && !ext_start_pin_n;
      acc_pkg::ACC_TRG_PLA:    trigHit = !plaPrev_q && programmable_logic_array_output;
      acc_pkg::ACC_TRG_TMR0:   trigHit = timer0Overflow;
      acc_pkg::ACC_TRG_TMR1:   trigHit = timer1Overflow;
      acc_pkg::ACC_TRG_SWSING: trigHit = swStart;
      acc_pkg::ACC_TRG_SWCONT: trigHit = swStart;
      default:                 trigHit = 1'b0;
    endcase
  end

  // enable only gates fresh starts; a running continuous series ignores it
  assign startReq = (trigHit && convEnable) || contRun_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      extPrev_q <= 1'b1;
      plaPrev_q <= 1'b0;
    end else begin
      extPrev_q <= ext_start_pin_n;
      plaPrev_q <= programmable_logic_array_output;
    end
  end

  // continuous mode latch: set by a software start, dropped when mode changes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      contRun_q <= 1'b0;
    end else if (acc_pkg::acc_trig_t'(trigSource) != acc_pkg::ACC_TRG_SWCONT) begin
      contRun_q <= 1'b0;
    end else if (swStart && convEnable) begin
      contRun_q <= 1'b1;
    end
  end

  // converter clock divider; temperature channel forces its own timing
  assign divLoad = (DIV_ONE_shift(divUse_q));
  assign tick    = (divCnt_q == acc_pkg::DIV_ONE);
  assign acqLoad = acc_pkg::ACQ_BASE << acqUse_q;

  function automatic logic [5:0] DIV_ONE_shift(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > acc_pkg::DIV_MAX) ? acc_pkg::DIV_MAX : sel;
    DIV_ONE_shift = acc_pkg::DIV_ONE << s;
  endfunction : DIV_ONE_shift

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_q <= acc_pkg::DIV_ONE;
    end else if (tick || state_q == acc_pkg::ACC_ST_IDLE) begin
      divCnt_q <= divLoad;
    end else begin
      divCnt_q <= divCnt_q - 6'h01;
    end
  end

  // timing latched per conversion; user values return after temperature read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      divUse_q <= acc_pkg::DIV_RST;
      acqUse_q <= acc_pkg::ACQ_RST;
    end else if (state_q == acc_pkg::ACC_ST_IDLE) begin
      if (channelSel == acc_pkg::TEMP_CH) begin
        divUse_q <= acc_pkg::DIV_TEMP;
        acqUse_q <= acc_pkg::ACQ_TEMP;
      end else begin
        divUse_q <= clkDivSel;
        acqUse_q <= acqTimeSel;
      end
    end
  end

  assign trialNext = sar_q | (12'h001 << bitIdx_q);

  // successive approximation sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= acc_pkg::ACC_ST_IDLE;
      sar_q        <= '0;
      bitIdx_q     <= '0;
      acqCnt_q     <= '0;
      sampleHold_q <= 1'b0;
      dacTrial_q   <= '0;
      muxChannel_q <= '0;
      muxTemp_q    <= 1'b0;
      muxMode_q    <= '0;
      busy_q       <= 1'b0;
    end else begin
      case (state_q)
        acc_pkg::ACC_ST_IDLE: begin
          busy_q       <= 1'b0;
          sampleHold_q <= 1'b0;
          if (startReq) begin
            muxChannel_q <= channelSel;
            muxTemp_q    <= (channelSel == acc_pkg::TEMP_CH);
            muxMode_q    <= inputMode;
            acqCnt_q     <= '0;
            busy_q       <= 1'b1;
            sampleHold_q <= 1'b1;
            state_q      <= acc_pkg::ACC_ST_ACQ;
          end
        end
        acc_pkg::ACC_ST_ACQ: begin
          if (acqCnt_q == 5'h00 && !tick) begin
            acqCnt_q <= 5'h00;
          end
          if (tick) begin
            acqCnt_q <= acqCnt_q + 5'h01;
            if (acqCnt_q + 5'h01 >= acqLoad) begin
              sampleHold_q <= 1'b0;
              sar_q        <= '0;
              bitIdx_q     <= acc_pkg::BIT_TOP;
              dacTrial_q   <= 12'h800;
              state_q      <= acc_pkg::ACC_ST_TRIAL;
            end
          end
        end
        acc_pkg::ACC_ST_TRIAL: begin
          if (tick) begin
            // keep the bit when the input sits above the trial level
            if (cmpAbove) sar_q[bitIdx_q] <= 1'b1;
            if (bitIdx_q == 4'h0) begin
              state_q <= acc_pkg::ACC_ST_WRITE;
            end else begin
              bitIdx_q   <= bitIdx_q - 4'h1;
              dacTrial_q <= (cmpAbove ? trialNext : sar_q) | (12'h001 << (bitIdx_q - 4'h1));
            end
          end
        end
        acc_pkg::ACC_ST_WRITE: begin
          // one cycle to hand the word to the queue; stalls while it is full
          if (fifoInReady) state_q <= acc_pkg::ACC_ST_IDLE;
        end
        default: state_q <= acc_pkg::ACC_ST_IDLE;
      endcase
    end
  end

  // result coding: differential flips the msb to twos complement, halves, extends sign
  always_comb begin
    resultWord = '0;
    if (acc_pkg::acc_mode_t'(muxMode_q) == acc_pkg::ACC_MODE_DIFF) begin
      resultWord[acc_pkg::RES_LSB +: acc_pkg::RES_W] =
        {~sar_q[11], ~sar_q[11], sar_q[10:1]};
      resultWord[acc_pkg::WORD_W-1 -: 4] = {4{~sar_q[11]}};
    end else begin
      resultWord[acc_pkg::RES_LSB +: acc_pkg::RES_W] = sar_q;
    end
  end

  assign pushResult = (state_q == acc_pkg::ACC_ST_WRITE);
  assign popResult  = resultRead || !resultValid_q;

  acc_fifo #(
    .WIDTH (acc_pkg::FIFO_W),
    .DEPTH (acc_pkg::FIFO_D)
  ) u_fifo (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .inValid  (pushResult),
    .inReady  (fifoInReady),
    .inData   (resultWord),
    .outValid (fifoOutValid),
    .outReady (popResult),
    .outData  (fifoOutData)
  );

  // visible result register and completion flag; a new word beats the read clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_result_register <= '0;
      resultValid_q  <= 1'b0;
      convComplete_q <= 1'b0;
    end else if (popResult && fifoOutValid) begin
      conversion_result_register <= fifoOutData;
      resultValid_q  <= 1'b1;
      convComplete_q <= 1'b1;
    end else if (resultRead) begin
      resultValid_q  <= 1'b0;
      convComplete_q <= 1'b0;
    end
  end

  // overrun: queue full while a word waits
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_q <= 1'b0;
    end else begin
      overrun_q <= pushResult && !fifoInReady;
    end
  end

  AST_TEMP_TIMING: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == acc_pkg::ACC_ST_IDLE && channelSel == acc_pkg::TEMP_CH) |=>
      (divUse_q == acc_pkg::DIV_TEMP && acqUse_q == acc_pkg::ACQ_TEMP))
    else $error("temperature timing not forced");
  AST_ENABLE_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == acc_pkg::ACC_ST_IDLE && !convEnable && !contRun_q) |=> !busy_q)
    else $error("start taken while disabled");
  AST_COMPLETE_CLR: assert property (@(posedge mclk) disable iff (!rst_n)
    (resultRead && !fifoOutValid) |=> !convComplete_q)
    else $error("complete flag not cleared by read");
  AST_SIGN_FILL: assert property (@(posedge mclk) disable iff (!rst_n)
    pushResult |-> (resultWord[31:28] == ((acc_pkg::acc_mode_t'(muxMode_q) == acc_pkg::ACC_MODE_DIFF) ?
      {4{resultWord[27]}} : 4'h0)))
    else $error("upper bits not sign filled");
  AST_TRIAL_COUNT: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(state_q == acc_pkg::ACC_ST_TRIAL) |-> bitIdx_q == acc_pkg::BIT_TOP)
    else $error("trial does not start at top bit");
  AST_HOLD_ACQ: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == acc_pkg::ACC_ST_ACQ) |-> sampleHold_q)
    else $error("sampling dropped during acquisition");
  AST_EXT_EDGE: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == acc_pkg::ACC_ST_IDLE && convEnable && trigSource == 3'h0 && extPrev_q && !ext_start_pin_n)
      |=> state_q == acc_pkg::ACC_ST_ACQ)
    else $error("pin start missed");
  AST_WRITE_ONE: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == acc_pkg::ACC_ST_WRITE && fifoInReady) |=> state_q == acc_pkg::ACC_ST_IDLE)
    else $error("result written more than once");
endmodule : acc_ctrl
`default_nettype wire

// File: core/acc_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module acc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // honest full and empty straight from the count
  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem_q[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // storage, written by index
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  // pointers and fill level
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= rdPtr_q + 1'b1;
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : acc_fifo
`default_nettype wire

// File: verification/acc_analog_model.sv
// behavioural analog front end: sample-and-hold and comparator
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model (
  input  wire logic        mclk,
  input  wire logic        sampleHold_q,
  input  wire logic        muxTemp_q,
  input  wire logic [11:0] dacTrial_q,
  input  wire logic [11:0] level,
  input  wire logic [11:0] tempLevel,
  output logic             cmpAbove
);
  logic [11:0] heldVal_q;
  // track while sampling, frozen during the bit trials
  always_ff @(posedge mclk) begin
    if (sampleHold_q) heldVal_q <= muxTemp_q ? tempLevel : level;
  end
  // ideal comparator, no offset, so the search lands exactly on the level
  assign cmpAbove = (heldVal_q >= dacTrial_q);
endmodule : acc_analog_model
`default_nettype wire

// File: verification/acc_ctrl_tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_tb_top;
  localparam logic [2:0] TRG [5] = '{acc_pkg::ACC_TRG_EXTPIN, acc_pkg::ACC_TRG_TMR0, acc_pkg::ACC_TRG_TMR1,
                                     acc_pkg::ACC_TRG_SWSING, acc_pkg::ACC_TRG_PLA};
  logic        mclk, rst_n, convEnable, swStart, extStartN, plaOut, tmr0, tmr1, cmpAbove, resultRead;
  logic        sampleHold, muxTemp, resultValid, convComplete, busy, overrun;
  logic [1:0]  inputMode, acqTimeSel, muxMode;
  logic [2:0]  trigSource, clkDivSel;
  logic [3:0]  channelSel, muxChannel;
  logic [11:0] level, tempLevel, dacTrial;
  logic [31:0] result, seed, contVal;
  logic [31:0] expQ [$];
  int          errors = 0, checks = 0, holdCnt = 0, holdLen = 0, lat = 0, nReads = 0;
  bit          stall = 0, contRun = 0, sawOverrun = 0;

  acc_ctrl acc_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .convEnable(convEnable), .inputMode(inputMode),
    .trigSource(trigSource), .clkDivSel(clkDivSel), .acqTimeSel(acqTimeSel), .channelSel(channelSel),
    .swStart(swStart), .ext_start_pin_n(extStartN), .programmable_logic_array_output(plaOut),
    .timer0Overflow(tmr0), .timer1Overflow(tmr1), .cmpAbove(cmpAbove), .resultRead(resultRead),
    .sampleHold_q(sampleHold), .muxTemp_q(muxTemp), .muxChannel_q(muxChannel), .muxMode_q(muxMode),
    .dacTrial_q(dacTrial), .resultValid_q(resultValid), .conversion_result_register(result),
    .convComplete_q(convComplete), .busy_q(busy), .overrun_q(overrun));
  acc_analog_model acc_analog_model_inst (.mclk(mclk), .sampleHold_q(sampleHold), .muxTemp_q(muxTemp),
    .dacTrial_q(dacTrial), .level(level), .tempLevel(tempLevel), .cmpAbove(cmpAbove));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // differential code is offset binary with msb flipped, then halved
  function automatic logic [31:0] expWord(input logic [1:0] m, input logic [11:0] c);
    logic [11:0] t;
    t = {~c[11], c[10:0]};
    if (m == acc_pkg::ACC_MODE_DIFF) return {{4{t[11]}}, t[11], t[11:1], 16'h0000};
    return {4'h0, c, 16'h0000};
  endfunction : expWord

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic print_verdict();
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // bounded wait until every noted result is read and the block is quiet
  task automatic waitIdle();
    int n;
    lat = 0;
    for (n = 1; n < 4000; n++) begin
      @(posedge mclk);
      #1;
      if (convComplete === 1'b1 && lat == 0) lat = n;
      if (expQ.size() == 0 && busy === 1'b0 && convComplete === 1'b0) break;
    end
    check("idle", 1, n < 4000);
  endtask : waitIdle

  task automatic fire(input logic [2:0] s);
    @(posedge mclk);
    case (s)
      acc_pkg::ACC_TRG_EXTPIN: extStartN <= 1'b0;
      acc_pkg::ACC_TRG_TMR0:   tmr0 <= 1'b1;
      acc_pkg::ACC_TRG_TMR1:   tmr1 <= 1'b1;
      acc_pkg::ACC_TRG_PLA:    plaOut <= 1'b1;
      default:                 swStart <= 1'b1;
    endcase
    @(posedge mclk);
    {extStartN, tmr0, tmr1, plaOut, swStart} <= 5'h10;
  endtask : fire

  task automatic convert(input logic [1:0] m, input logic [2:0] s);
    logic [31:0] r;
    r = rnd();
    @(posedge mclk);
    inputMode <= m;
    trigSource <= s;
    level <= r[11:0];
    tempLevel <= r[27:16];
    expQ.push_back(expWord(m, (channelSel == acc_pkg::TEMP_CH) ? r[27:16] : r[11:0]));
    fire(s);
    #1 check("muxMode", m, muxMode);
    check("muxTemp", channelSel == acc_pkg::TEMP_CH, muxTemp);
    check("muxChannel", channelSel, muxChannel);
    waitIdle();
  endtask : convert

  // acquisition length and overrun watch
  always @(posedge mclk) begin
    if (sampleHold === 1'b1) holdCnt <= holdCnt + 1;
    else if (holdCnt != 0) begin
      holdLen <= holdCnt;
      holdCnt <= 0;
      check("firstTrial", 12'h800, dacTrial);
    end
    if (overrun === 1'b1) sawOverrun <= 1'b1;
  end

  // reader: compares each completed word against the oldest note, or against the continuous value when no note is left
  initial begin
    logic [31:0] e;
    forever begin
      @(posedge mclk);
      #1;
      if (convComplete === 1'b1 && !stall) begin
        if (expQ.size() > 0) e = expQ.pop_front();
        else if (contRun) e = contVal;
        else e = ~result;
        check("result", e, result);
        check("resultValid", 1, resultValid);
        nReads++;
        @(posedge mclk);
        resultRead <= 1'b1;
        @(posedge mclk);
        resultRead <= 1'b0;
      end
    end
  end

  // watchdog, a few times the expected run of about three and a half thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    $display("MISMATCH watchdog expected done seen timeout");
    print_verdict();
  end

  initial begin
    logic [31:0] v;
    seed = 32'hd8c6;
    {rst_n, swStart, plaOut, tmr0, tmr1, resultRead} = 6'h00;
    {convEnable, extStartN, inputMode, trigSource} = {2'h3, acc_pkg::ACC_MODE_SINGLE, acc_pkg::ACC_TRG_SWSING};
    {clkDivSel, acqTimeSel, channelSel} = {acc_pkg::DIV_RST, acc_pkg::ACQ_RST, 4'h0};
    {level, tempLevel} = 24'h000000;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    // every input configuration against every one-shot trigger source
    for (int m = 0; m < 3; m++)
      for (int t = 0; t < 5; t++) convert(2'(m), TRG[t]);
    // acquisition length per code, divider rising with it; hold lasts divide times acq clocks
    for (int a = 0; a < 4; a++) begin
      acqTimeSel <= 2'(a);
      clkDivSel <= 3'(a + 1);
      convert(acc_pkg::ACC_MODE_SINGLE, acc_pkg::ACC_TRG_SWSING);
      check("acqLen", 1, holdLen >= ((2 << a) * (2 << a)) && holdLen <= ((2 << a) * (2 << a)) + 2);
    end
    // fastest timing, then the temperature channel, then user timing again
    clkDivSel <= 3'h0;
    acqTimeSel <= 2'h0;
    convert(acc_pkg::ACC_MODE_SINGLE, acc_pkg::ACC_TRG_SWSING);
    check("latency", 1, lat <= 40);
    channelSel <= acc_pkg::TEMP_CH;
    convert(acc_pkg::ACC_MODE_PSEUDO, acc_pkg::ACC_TRG_SWSING);
    check("tempAcq", 1, holdLen >= 512 && holdLen <= 544);
    channelSel <= 4'h0;
    convert(acc_pkg::ACC_MODE_SINGLE, acc_pkg::ACC_TRG_SWSING);
    check("userAcq", 1, holdLen >= 2 && holdLen <= 3);
    // disabled block ignores a start
    convEnable <= 1'b0;
    fire(acc_pkg::ACC_TRG_SWSING);
    repeat (60) @(posedge mclk);
    #1 check("refused", 0, {busy, convComplete});
    // continuous run, disabled after start, reader stalled until the queue refuses
    v = rnd();
    level <= v[11:0];
    contVal = expWord(acc_pkg::ACC_MODE_SINGLE, v[11:0]);
    {contRun, stall} = 2'h3;
    convEnable <= 1'b1;
    trigSource <= acc_pkg::ACC_TRG_SWCONT;
    fire(acc_pkg::ACC_TRG_SWCONT);
    convEnable <= 1'b0;
    repeat (800) @(posedge mclk);
    #1 check("overrun", 1, sawOverrun);
    nReads = 0;
    stall = 0;
    @(posedge mclk);
    trigSource <= acc_pkg::ACC_TRG_SWSING;
    waitIdle();
    check("drained", 1, nReads >= acc_pkg::FIFO_D + 1);
    contRun = 0;
    print_verdict();
  end
endmodule : acc_ctrl_tb_top
`default_nettype wire
